/* sremu_top.sv */
// standby ram with timer emulation: bus decode, control registers and sequencer
// Overview of operation
// - 3.5 kbyte array low in 4 kbyte region
// - array answers program and data space
// - registers decoded in supervisor data only
// - eight byte block, unused reads zero
// - base bits 15:4 match address 23:12
// - upper 512 bytes of region ignored
// - base register lsb shows array disable
// - disabled after reset or on overlap
// - valid base write enables the array
// - base register locks after first write
// - supervisor-only mode ignores user accesses
// - word two clocks, long two cycles
// - timer port ignored outside emulation
// - no bus access to the array while on standby supply
// - stop bit blocks bus access to the array, keeps contents
// - stop written only at supervisor level
// - stop set by reset, software clears
// - reset: stop, supervisor, base cleared, disabled
// - reset waits for byte/word completion
// - long word: reset splits after first word
// - timer selects emulation, dedicated read bus
// - emulation ignores bus and registers
`timescale 1ns/100ps
`default_nettype none

module sremu_top #(
    parameter logic [23:0] REG_ADDR = sremu_pkg::REG_BLOCK_ADDR
) (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    // internal module bus, master side
    input  wire logic        bus_req_i,
    input  wire logic [23:0] bus_addr_i,
    input  wire logic [1:0]  transfer_size_i,
    input  wire logic        bus_write_i,
    input  wire logic        bus_super_i,
    input  wire logic        bus_prog_i,
    input  wire logic [15:0] bus_wdata_i,
    output logic      [15:0] bus_rdata_o,
    output logic             bus_ack_o,
    // system level
    input  wire logic        module_map_bit_i,
    input  wire logic        standby_supply_input_i,
    // timer coprocessor dedicated bus
    input  wire logic        emu_mode_i,
    input  wire logic        tpu_rd_i,
    input  wire logic [10:0] tpu_addr_i,
    output logic      [15:0] tpu_rdata_o
);
    // ****************************************************************
    // state
    // ****************************************************************
    sremu_pkg::sremu_state_type state_reg, state_next;
    logic        rst_pend_reg, rst_pend_next;   // reset held off by a bus access
    logic        stop_reg, stop_next;           // low-power stop
    logic        priv_reg, priv_next;           // 1 = supervisor only
    logic [12:0] base_reg, base_next;           // bits 12:1 compare to address 23:12
    logic        dis_reg, dis_next;             // array_disable_flag
    logic        lock_reg, lock_next;           // base write lock
    logic        long_reg, long_next;           // access is a long word
    logic        reg_tgt_reg, reg_tgt_next;     // access targets registers
    logic [23:0] hold_addr_reg, hold_addr_next; // address of the first word
    logic [15:0] rdata_reg, rdata_next;
    logic        stby_meta_reg, stby_sync_reg;  // standby supply synchroniser

    // ****************************************************************
    // decode
    // ****************************************************************
    logic [23:0] blk_addr;      // register block with the map bit applied
    logic        rst_any;
    logic        do_reset;
    logic        array_sel;     // address inside the active array window
    logic        array_ok;
    logic        reg_hit;
    logic        take;
    logic        phase;         // a word transfer happens on this edge
    logic [23:0] acc_addr;
    logic [1:0]  be;
    logic [1:0]  arr_we;
    logic [15:0] arr_rdata;
    logic [15:0] reg_rdata;
    logic [12:0] new_base;

    assign blk_addr = {module_map_bit_i, REG_ADDR[22:0]};

    // a base is valid when 4 kbyte aligned and clear of the register block
    function automatic logic base_valid(input logic [12:0] b, input logic [23:0] blk);
        logic ovl;
        ovl = (blk[23:12] == b[12:1]) && (blk[11:0] < sremu_pkg::ARRAY_LIMIT);
        return !ovl && !b[0];
    endfunction

    // synchronous reset is deferred to a word boundary of a running access
    assign rst_any  = reset_i | rst_pend_reg;
    assign do_reset = rst_any && (state_reg != sremu_pkg::ST_SECOND_ADDR);

    // region match, then lower 3.5 kbyte only
    assign array_sel = (bus_addr_i[23:12] == base_reg[12:1])
                     && (bus_addr_i[11:0] < sremu_pkg::ARRAY_LIMIT)
                     && !dis_reg;
    // program and data space both served; user cycles left unterminated in supervisor-only mode
    assign array_ok = array_sel && !stop_reg && !stby_sync_reg
                    && (bus_super_i || !priv_reg);
    assign reg_hit  = (bus_addr_i[23:3] == blk_addr[23:3])
                    && bus_super_i && !bus_prog_i;
    assign take = (state_reg == sremu_pkg::ST_IDLE) && bus_req_i && !do_reset
                && !emu_mode_i && (array_ok || reg_hit);

    assign phase    = take || (state_reg == sremu_pkg::ST_SECOND_ADDR);
    assign acc_addr = take ? bus_addr_i : hold_addr_reg + 24'h000002;
    // even byte address sits on the upper lane
    assign be = (take && transfer_size_i == sremu_pkg::SIZE_BYTE)
              ? (bus_addr_i[0] ? 2'b01 : 2'b10) : 2'b11;
    assign arr_we = (phase && bus_write_i && !(take ? reg_hit : reg_tgt_reg)) ? be : 2'b00;

    // ****************************************************************
    // array instance
    // ****************************************************************
    sremu_array u_array (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .a_we_i    (arr_we),
        .a_addr_i  (acc_addr[11:1]),
        .a_wdata_i (bus_wdata_i),
        .a_rdata_o (arr_rdata),
        .b_rd_i    (emu_mode_i && tpu_rd_i),
        .b_addr_i  (tpu_addr_i),
        .b_rdata_o (tpu_rdata_o)
    );

    // ****************************************************************
    // register read mux
    // ****************************************************************
    always_comb
    begin
        reg_rdata = 16'h0000;
        case ({acc_addr[2:1], 1'b0})
            sremu_pkg::MCR_OFS:
            begin
                reg_rdata[sremu_pkg::MCR_STOP_BIT] = stop_reg;
                reg_rdata[sremu_pkg::MCR_PRIV_BIT] = priv_reg;
            end
            sremu_pkg::BAR_OFS:
            begin
                reg_rdata[15:3] = base_reg;
                reg_rdata[sremu_pkg::BAR_DIS_BIT] = dis_reg;
            end
            default:
            begin
                reg_rdata = 16'h0000;   // test register reads zero
            end
        endcase
    end

    // base candidate merges only the written byte lanes
    assign new_base = {be[1] ? bus_wdata_i[15:8] : base_reg[12:5],
                       be[0] ? bus_wdata_i[7:3]  : base_reg[4:0]};

    // ****************************************************************
    // sequencer next state
    // ****************************************************************
    always_comb
    begin
        state_next     = state_reg;
        long_next      = long_reg;
        reg_tgt_next   = reg_tgt_reg;
        hold_addr_next = hold_addr_reg;
        rdata_next     = rdata_reg;
        rst_pend_next  = do_reset ? 1'b0 : rst_any;
        case (state_reg)
            sremu_pkg::ST_IDLE:
            begin
                if (take)
                begin
                    state_next     = sremu_pkg::ST_FIRST;
                    long_next      = (transfer_size_i == sremu_pkg::SIZE_LONG)
                                   || (transfer_size_i == 2'h3);
                    reg_tgt_next   = reg_hit;
                    hold_addr_next = bus_addr_i;
                end
            end
            sremu_pkg::ST_FIRST:
            begin
                // a pending reset drops the second word
                state_next = (long_reg && !rst_any) ? sremu_pkg::ST_SECOND_ADDR
                                                    : sremu_pkg::ST_IDLE;
            end
            sremu_pkg::ST_SECOND_ADDR:
            begin
                state_next = sremu_pkg::ST_SECOND;
            end
            default:
            begin
                state_next = sremu_pkg::ST_IDLE;
            end
        endcase
        if (phase)
        begin
            rdata_next = (take ? reg_hit : reg_tgt_reg) ? reg_rdata : arr_rdata;
        end
        if (do_reset)
        begin
            state_next = sremu_pkg::ST_IDLE;
        end
    end

    // ****************************************************************
    // control register next state
    // ****************************************************************
    always_comb
    begin
        stop_next = stop_reg;
        priv_next = priv_reg;
        base_next = base_reg;
        dis_next  = dis_reg;
        lock_next = lock_reg;
        if (do_reset)
        begin
            stop_next = sremu_pkg::STOP_RST;
            priv_next = sremu_pkg::PRIV_RST;
            base_next = sremu_pkg::BASE_RST;
            dis_next  = sremu_pkg::DIS_RST;
            lock_next = 1'b0;
        end
        else if (phase && bus_write_i && (take ? reg_hit : reg_tgt_reg))
        begin
            // writes to other offsets are discarded
            if ({acc_addr[2:1], 1'b0} == sremu_pkg::MCR_OFS && be[1] && bus_super_i)
            begin
                stop_next = bus_wdata_i[sremu_pkg::MCR_STOP_BIT];
                priv_next = bus_wdata_i[sremu_pkg::MCR_PRIV_BIT];
            end
            if ({acc_addr[2:1], 1'b0} == sremu_pkg::BAR_OFS && !lock_reg)
            begin
                base_next = new_base;
                dis_next  = !base_valid(new_base, blk_addr);
                lock_next = 1'b1;
            end
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            stby_meta_reg <= 1'b0;
            stby_sync_reg <= 1'b0;
        end
        else
        begin
            stby_meta_reg <= standby_supply_input_i;
            stby_sync_reg <= stby_meta_reg;
        end
    end

    // reset is applied through do_reset so running accesses can finish
    always_ff @(posedge sys_clk_i)
    begin
        state_reg     <= state_next;
        rst_pend_reg  <= rst_pend_next;
        long_reg      <= long_next;
        reg_tgt_reg   <= reg_tgt_next;
        hold_addr_reg <= hold_addr_next;
        rdata_reg     <= rdata_next;
        stop_reg      <= stop_next;
        priv_reg      <= priv_next;
        base_reg      <= base_next;
        dis_reg       <= dis_next;
        lock_reg      <= lock_next;
    end

    // one ack per word, one clock after its address edge
    assign bus_ack_o   = (state_reg == sremu_pkg::ST_FIRST)
                       || (state_reg == sremu_pkg::ST_SECOND);
    assign bus_rdata_o = rdata_reg;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    word_timing_a: assert property (take && transfer_size_i != sremu_pkg::SIZE_LONG
        && transfer_size_i != 2'h3 |=> bus_ack_o ##1 !bus_ack_o)
        else $error("word access not acked once after one clock");
    long_timing_a: assert property (take && transfer_size_i == sremu_pkg::SIZE_LONG
        ##1 !rst_any |-> bus_ack_o ##1 !bus_ack_o ##1 bus_ack_o)
        else $error("long word not two bus cycles");
    user_ignored_a: assert property (bus_req_i && !bus_super_i && priv_reg
        && state_reg == sremu_pkg::ST_IDLE |=> !bus_ack_o)
        else $error("user access terminated in supervisor mode");
    emu_ignore_a: assert property (emu_mode_i && state_reg == sremu_pkg::ST_IDLE
        |=> !bus_ack_o)
        else $error("bus access taken during emulation");
    stop_block_a: assert property (stop_reg && !reg_hit && state_reg == sremu_pkg::ST_IDLE
        |=> !bus_ack_o)
        else $error("array access while stopped");
    upper_free_a: assert property (bus_addr_i[11:0] >= sremu_pkg::ARRAY_LIMIT && !reg_hit
        && state_reg == sremu_pkg::ST_IDLE |=> !bus_ack_o)
        else $error("upper 512 bytes answered");
    standby_block_a: assert property (stby_sync_reg && !reg_hit
        && state_reg == sremu_pkg::ST_IDLE |=> !bus_ack_o)
        else $error("array access on standby supply");
    base_lock_a: assert property (lock_reg && !do_reset |=> $stable(base_reg))
        else $error("locked base register changed");
    reset_finish_a: assert property (disable iff (1'b0)
        state_reg == sremu_pkg::ST_SECOND_ADDR && rst_any
        |=> bus_ack_o ##1 (stop_reg && dis_reg))
        else $error("second word not finished before reset");
    timer_quiet_a: assert property (!emu_mode_i |=> $stable(tpu_rdata_o))
        else $error("timer port active outside emulation");
    dis_flag_a: assert property (bus_ack_o && reg_tgt_reg && !bus_write_i
        && hold_addr_reg[2:1] == 2'b10 |-> bus_rdata_o[0] == $past(dis_reg))
        else $error("disable flag not on base lsb");

    long_cov_c:  cover property (take && long_next ##3 bus_ack_o);
    bar_cov_c:   cover property (lock_reg && !dis_reg);
    split_cov_c: cover property (disable iff (1'b0)
        state_reg == sremu_pkg::ST_FIRST && long_reg && reset_i);
endmodule // sremu_top

`default_nettype wire

/* sremu_array.sv */
// shared constants and the dual-port storage array of the standby ram block
`timescale 1ns/100ps
`default_nettype none

package sremu_pkg;
    // ****************************************************************
    // bus and array geometry
    // ****************************************************************
    localparam int          ADDR_W        = 24;         // internal bus address width
    localparam int          DATA_W        = 16;         // internal bus data width
    localparam int          LANES         = 2;          // byte lanes per word
    localparam int          ARRAY_WORDS   = 1792;       // 3.5 kbyte as 16-bit words
    localparam int          WORD_AW       = 11;         // word index width
    localparam logic [11:0] ARRAY_LIMIT   = 12'he00;    // top 512 bytes of 4 kbyte left free
    // ****************************************************************
    // control register block
    // ****************************************************************
    localparam logic [23:0] REG_BLOCK_ADDR = 24'h7ffb40; // bit 23 comes from the map bit
    localparam logic [2:0]  MCR_OFS       = 3'h0;       // module_config_register
    localparam logic [2:0]  TST_OFS       = 3'h2;       // module_test_register
    localparam logic [2:0]  BAR_OFS       = 3'h4;       // array_base_and_disable
    localparam int          MCR_STOP_BIT  = 15;         // low-power stop bit
    localparam int          MCR_PRIV_BIT  = 8;          // privilege_space_field, 1 = supervisor
    localparam int          BAR_DIS_BIT   = 0;          // array_disable_flag
    localparam logic        STOP_RST      = 1'b1;
    localparam logic        PRIV_RST      = 1'b1;
    localparam logic        DIS_RST       = 1'b1;
    localparam logic [12:0] BASE_RST      = 13'h0000;
    // ****************************************************************
    // transfer size encodings
    // ****************************************************************
    localparam logic [1:0]  SIZE_LONG     = 2'h0;
    localparam logic [1:0]  SIZE_BYTE     = 2'h1;
    localparam logic [1:0]  SIZE_WORD     = 2'h2;
    // access sequencer states
    typedef enum logic [1:0] {
        ST_IDLE        = 2'b00,
        ST_FIRST       = 2'b01,
        ST_SECOND_ADDR = 2'b10,
        ST_SECOND      = 2'b11
    } sremu_state_type;
endpackage

// ****************************************************************
// storage: port a read/write for the bus, port b read for the timer
// ****************************************************************
module sremu_array #(
    parameter int DEPTH = sremu_pkg::ARRAY_WORDS,
    parameter int AW    = sremu_pkg::WORD_AW
) (
    // clock and reset
    input  wire logic                        sys_clk_i,
    input  wire logic                        reset_i,
    // bus port, combinational read
    input  wire logic [sremu_pkg::LANES-1:0] a_we_i,
    input  wire logic [AW-1:0]               a_addr_i,
    input  wire logic [sremu_pkg::DATA_W-1:0] a_wdata_i,
    output logic      [sremu_pkg::DATA_W-1:0] a_rdata_o,
    // timer port, registered read like a rom
    input  wire logic                        b_rd_i,
    input  wire logic [AW-1:0]               b_addr_i,
    output logic      [sremu_pkg::DATA_W-1:0] b_rdata_o
);
    logic [sremu_pkg::DATA_W-1:0] mem [DEPTH];   // array contents, never reset
    logic [sremu_pkg::DATA_W-1:0] b_rdata_reg;   // timer read data
    logic [sremu_pkg::DATA_W-1:0] b_rdata_next;

    // per-lane byte writes
    for (genvar l = 0; l < sremu_pkg::LANES; l++)
    begin : g_lane
        always_ff @(posedge sys_clk_i)
        begin
            if (a_we_i[l])
            begin
                mem[a_addr_i][l*8 +: 8] <= a_wdata_i[l*8 +: 8];
            end
        end
    end

    // bus read is combinational; the top registers it
    assign a_rdata_o = mem[a_addr_i];

    // timer read holds its last value when idle
    always_comb
    begin
        b_rdata_next = b_rd_i ? mem[b_addr_i] : b_rdata_reg;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            b_rdata_reg <= '0;
        end
        else
        begin
            b_rdata_reg <= b_rdata_next;
        end
    end

    assign b_rdata_o = b_rdata_reg;
endmodule // sremu_array

`default_nettype wire

/* sremu_master.sv */
// bus master model that drives the internal module bus of the standby ram
`timescale 1ns/100ps
`default_nettype none

module sremu_master (
    // clock
    input  wire logic        sys_clk_i,
    // request side
    output logic             bus_req_o,
    output logic      [23:0] bus_addr_o,
    output logic      [1:0]  size_o,
    output logic             write_o,
    output logic             super_o,
    output logic             prog_o,
    output logic      [15:0] wdata_o,
    // answer side
    input  wire logic [15:0] rdata_i,
    input  wire logic        ack_i
);
    // ****************************************************************
    // idle bus at time zero
    // ****************************************************************
    initial
    begin
        bus_req_o  = 1'b0;
        bus_addr_o = 24'hffffff;
        size_o     = 2'h2;
        write_o    = 1'b0;
        super_o    = 1'b0;
        prog_o     = 1'b0;
        wdata_o    = 16'hffff;
    end

    // one transfer, qualifiers held to the last ack; refused ones end after eight edges
    task automatic xfer(input logic [23:0] a, input logic [1:0] sz, input logic wr, sup, prg,
                        input logic [31:0] wd, output logic [31:0] rd, output int acks,
                        output int lat);
        int need;
        need = (sz == sremu_pkg::SIZE_LONG) ? 2 : 1;
        rd   = 32'h0;
        acks = 0;
        lat  = 0;
        @(posedge sys_clk_i);
        bus_req_o  <= 1'b1;
        bus_addr_o <= a;
        size_o     <= sz;
        write_o    <= wr;
        super_o    <= sup;
        prog_o     <= prg;
        wdata_o    <= (need == 2) ? wd[31:16] : wd[15:0];
        for (int n = 1; n <= 8 && acks < need; n++)
        begin
            @(posedge sys_clk_i);
            bus_req_o <= 1'b0;
            // answer taken at the edge where ack is sampled high
            if (ack_i === 1'b1)
            begin
                acks++;
                lat = n;
                rd  = {rd[15:0], rdata_i};
                // second word of a long follows the first ack
                if (acks < need)
                    wdata_o <= wd[15:0];
            end
        end
        // released address and data lines show the inverse, never a stale copy
        bus_addr_o <= ~a;
        wdata_o    <= ~wd[15:0];
    endtask
endmodule // sremu_master

`default_nettype wire

/* standby_ram_with_timer_emulation_bench.sv */
// self-checking bench of the standby ram with timer emulation
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
    $display("[ERR] t=%0t got %h exp %h", $time, got, exp); end end

module standby_ram_with_timer_emulation_bench;
    // row of the array table
    typedef struct {
        logic [23:0] a;
        logic [1:0]  sz;
        logic [2:0]  wsp;   // write, supervisor, program
        logic [31:0] wd;
        int          n;
        logic [31:0] rd;
    } sremu_row_type;
    // ****************************************************************
    // bench signals
    // ****************************************************************
    logic          sys_clk = 1'b0; // 100 mhz
    logic          reset = 1'b1; // synchronous, high
    logic          map_bit = 1'b0; // top address bit of registers
    logic          standby = 1'b0; // array on standby supply
    logic          emu = 1'b0, tpu_rd = 1'b0; // emulation select, timer strobe
    logic [10:0]   tpu_addr = 11'h0;
    logic [15:0]   tpu_rdata, wdata, rdata;
    logic          req, wr, sup, prg, ack; // strobe, qualifiers, termination
    logic [23:0]   addr;
    logic [1:0]    size;
    int            miscompares = 0, cmp_count = 0;
    sremu_row_type rows [13]; // ordinary array cases
    localparam logic [23:0] RB = {1'b0, sremu_pkg::REG_BLOCK_ADDR[22:0]}; // map bit 0

    always #5 sys_clk = ~sys_clk;

    sremu_top u_dut (.sys_clk_i(sys_clk), .reset_i(reset), .bus_req_i(req), .bus_addr_i(addr),
        .transfer_size_i(size), .bus_write_i(wr), .bus_super_i(sup), .bus_prog_i(prg),
        .bus_wdata_i(wdata), .bus_rdata_o(rdata), .bus_ack_o(ack), .module_map_bit_i(map_bit),
        .standby_supply_input_i(standby), .emu_mode_i(emu), .tpu_rd_i(tpu_rd),
        .tpu_addr_i(tpu_addr), .tpu_rdata_o(tpu_rdata));
    sremu_master u_mst (.sys_clk_i(sys_clk), .bus_req_o(req), .bus_addr_o(addr), .size_o(size),
        .write_o(wr), .super_o(sup), .prog_o(prg), .wdata_o(wdata), .rdata_i(rdata),
        .ack_i(ack));

    // ****************************************************************
    // tasks
    // ****************************************************************
    // verdict and end of run, shared with the watchdog
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // one transfer, acks, latency and read data checked
    task automatic bus(input logic [23:0] a, input logic [1:0] sz, input logic w, s, p,
                       input logic [31:0] wd, input int n_exp, input logic [31:0] rd_exp);
        logic [31:0] rd;
        int          acks;
        int          lat;
        u_mst.xfer(a, sz, w, s, p, wd, rd, acks, lat);
        `CHECK(acks, n_exp)
        if (n_exp > 0)
            `CHECK(lat, 2 * n_exp)
        if (n_exp > 0 && !w)
            `CHECK(rd, rd_exp)
    endtask
    // refused word read in data space
    task automatic miss(input logic [23:0] a, input logic s);
        bus(a, 2'h2, 1'b0, s, 1'b0, 0, 0, 0);
    endtask
    // register word read and write, supervisor data space
    task automatic rd_reg(input logic [2:0] ofs, input logic [15:0] v);
        bus({map_bit, sremu_pkg::REG_BLOCK_ADDR[22:3], ofs}, 2'h2, 1'b0, 1'b1, 1'b0, 32'h0, 1,
            {16'h0, v});
    endtask
    task automatic wr_reg(input logic [2:0] ofs, input logic [15:0] v);
        bus({map_bit, sremu_pkg::REG_BLOCK_ADDR[22:3], ofs}, 2'h2, 1'b1, 1'b1, 1'b0, {16'h0, v},
            1, 32'h0);
    endtask
    // base in one word, stop cleared
    task automatic init_base;
        wr_reg(sremu_pkg::BAR_OFS, 16'h0120);
        wr_reg(sremu_pkg::MCR_OFS, 16'h0000);
    endtask
    // reset for two edges, d edges in
    task automatic mid_reset(input int d);
        repeat (d) @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
    endtask

    // watchdog: the run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        end_of_test;
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        rows = '{'{24'h012000, 2'h2, 3'b110, 32'h5a5a, 1, 32'h0},
                 '{24'h012001, 2'h1, 3'b100, 32'h3c3c, 1, 32'h0},
                 '{24'h012000, 2'h2, 3'b001, 32'h0, 1, 32'h5a3c},
                 '{24'h012004, 2'h0, 3'b110, 32'h11223344, 2, 32'h0},
                 '{24'h012006, 2'h2, 3'b011, 32'h0, 1, 32'h3344},
                 '{24'h012004, 2'h1, 3'b110, 32'heeee, 1, 32'h0},
                 '{24'h012004, 2'h0, 3'b000, 32'h0, 2, 32'hee223344},
                 '{24'h012dfe, 2'h2, 3'b110, 32'hbeef, 1, 32'h0},
                 '{24'h012dfe, 2'h2, 3'b010, 32'h0, 1, 32'hbeef},
                 '{24'h012e00, 2'h2, 3'b010, 32'h0, 0, 32'h0},
                 '{24'h012e00, 2'h2, 3'b110, 32'hdead, 0, 32'h0},
                 '{24'h013000, 2'h2, 3'b010, 32'h0, 0, 32'h0},
                 '{24'h812000, 2'h2, 3'b010, 32'h0, 0, 32'h0}};
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        // reset values, unused places, space checks
        rd_reg(sremu_pkg::MCR_OFS, 16'h8100);
        rd_reg(sremu_pkg::BAR_OFS, 16'h0001);
        wr_reg(sremu_pkg::TST_OFS, 16'hffff);
        rd_reg(sremu_pkg::TST_OFS, 16'h0000);
        rd_reg(3'h6, 16'h0000);
        miss(RB, 1'b0);
        bus(RB, 2'h2, 1'b0, 1'b1, 1'b1, 0, 0, 0);
        miss(24'h000000, 1'b1);
        // base over the register block stays disabled
        wr_reg(sremu_pkg::BAR_OFS, 16'h7ff0);
        rd_reg(sremu_pkg::BAR_OFS, 16'h7ff1);
        reset <= 1'b1;
        map_bit <= 1'b1;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        rd_reg(sremu_pkg::MCR_OFS, 16'h8100);
        map_bit <= 1'b0;
        @(posedge sys_clk);
        init_base;
        rd_reg(sremu_pkg::BAR_OFS, 16'h0120);
        wr_reg(sremu_pkg::BAR_OFS, 16'h0340);
        rd_reg(sremu_pkg::BAR_OFS, 16'h0120);
        // user cannot touch stop; stop blocks the array
        bus(RB, 2'h2, 1'b1, 1'b0, 1'b0, 0, 0, 0);
        wr_reg(sremu_pkg::MCR_OFS, 16'h8000);
        miss(24'h012000, 1'b1);
        wr_reg(sremu_pkg::MCR_OFS, 16'h0000);
        $display("test registers done");
        foreach (rows[i])
            bus(rows[i].a, rows[i].sz, rows[i].wsp[2], rows[i].wsp[1], rows[i].wsp[0],
                rows[i].wd, rows[i].n, rows[i].rd);
        $display("test array done");
        // supervisor only, standby supply, retention after standby
        wr_reg(sremu_pkg::MCR_OFS, 16'h0100);
        miss(24'h012000, 1'b0);
        wr_reg(sremu_pkg::MCR_OFS, 16'h0000);
        standby <= 1'b1;
        repeat (3) @(posedge sys_clk);
        miss(24'h012000, 1'b1);
        standby <= 1'b0;
        repeat (3) @(posedge sys_clk);
        bus(24'h012000, 2'h2, 1'b0, 1'b0, 1'b0, 0, 1, 32'h5a3c);
        $display("test access guards done");
        // emulation: timer reads, bus and registers shut out
        emu <= 1'b1;
        tpu_rd <= 1'b1;
        tpu_addr <= 11'h000;
        @(posedge sys_clk);
        tpu_rd <= 1'b0;
        tpu_addr <= 11'h7ff;
        @(posedge sys_clk);
        `CHECK(tpu_rdata, 16'h5a3c)
        miss(24'h012000, 1'b1);
        miss(RB, 1'b1);
        emu <= 1'b0;
        tpu_rd <= 1'b1;
        tpu_addr <= 11'h002;
        @(posedge sys_clk);
        tpu_rd <= 1'b0;
        @(posedge sys_clk);
        `CHECK(tpu_rdata, 16'h5a3c)
        $display("test emulation done");
        // reset during a word, first long word, second long word
        fork
            bus(24'h012010, 2'h2, 1'b1, 1'b1, 1'b0, 32'h1234, 1, 0);
            mid_reset(2);
        join
        rd_reg(sremu_pkg::BAR_OFS, 16'h0001);
        init_base;
        bus(24'h012010, 2'h2, 1'b0, 1'b1, 1'b0, 0, 1, 32'h1234);
        bus(24'h012020, 2'h0, 1'b1, 1'b1, 1'b0, 32'h0, 2, 0);
        fork
            bus(24'h012020, 2'h0, 1'b1, 1'b1, 1'b0, 32'haaaabbbb, 1, 0);
            mid_reset(2);
        join
        init_base;
        bus(24'h012020, 2'h0, 1'b0, 1'b1, 1'b0, 0, 2, 32'haaaa0000);
        fork
            bus(24'h012030, 2'h0, 1'b1, 1'b1, 1'b0, 32'hccccdddd, 2, 0);
            mid_reset(3);
        join
        init_base;
        bus(24'h012030, 2'h0, 1'b0, 1'b1, 1'b0, 0, 2, 32'hccccdddd);
        $display("test deferred reset done");
        end_of_test;
    end
endmodule // standby_ram_with_timer_emulation_bench

`default_nettype wire
